//--- logic/wdt_top.sv
// watchdog timer with key protection, reset-cause flag and APB register file
//
// Added by the designer: the register offsets and the APB slave port.
`timescale 1ns/1ps
`include "wdt_consts.svh"

module wdt_top #(
  parameter int unsigned KEY_FAULT_CYCLES = `WDT_KEY_FAULT_CYC
) (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // apb slave
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // cpu core
  input  wire logic        watchdog_clear_instruction,
  input  wire logic        sleep_instruction,
  input  wire logic        cpu_low_power,
  output logic             cpu_reset,
  output logic             pc_sp_reset,
  output logic             irq,
  // pins
  input  wire logic        slow_rc_clock,
  input  wire logic        ext_nrst_pin
);

  // ----------------------------------------
  // reset release
  // ----------------------------------------
  logic [1:0] rst_sync;
  logic       rst_sys_n;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end

  assign rst_sys_n = rst_sync[1];

  // ----------------------------------------
  // pins and counter
  // ----------------------------------------
  logic rc_rise;
  logic pin_lvl;

  wdt_cnt_if ci ();

  wdt_sync3 #(
    .INIT      (1'b0)
  ) u_rc_sync (
    .clk_sys   (clk_sys),
    .rst_sys_n (rst_sys_n),
    .d         (slow_rc_clock),
    .lvl       (),
    .rise      (rc_rise),
    .fall      ()
  );

  // pin idles high so a released reset does not look like a reset request
  wdt_sync3 #(
    .INIT      (1'b1)
  ) u_pin_sync (
    .clk_sys   (clk_sys),
    .rst_sys_n (rst_sys_n),
    .d         (ext_nrst_pin),
    .lvl       (pin_lvl),
    .rise      (),
    .fall      ()
  );

  wdt_counter u_counter (
    .clk_sys   (clk_sys),
    .rst_sys_n (rst_sys_n),
    .ci        (ci)
  );

  // ----------------------------------------
  // state
  // ----------------------------------------
  localparam logic [`WDT_FCNT_W-1:0] FCNT_LOAD = `WDT_FCNT_W'(KEY_FAULT_CYCLES - 1);

  localparam wdt_pkg::wdt_top_s ST_RST = '{
    ctrl:       `WDT_CTRL_POR,
    pinkey:     `WDT_PINKEY_POR,
    key_fault:  1'b0,
    timeout:    1'b0,
    pdown:      1'b0,
    irq_stat:   2'h0,
    irq_mask:   2'h0,
    fault:      wdt_pkg::WDT_F_IDLE,
    fcnt:       '0,
    prdata:     32'h00000000,
    cpu_reset:  1'b1,
    pcsp_reset: 1'b0
  };

  wdt_pkg::wdt_top_s st;
  wdt_pkg::wdt_top_s next_st;

  logic        wr;
  logic        rd;
  logic        addr_ok;
  logic [4:0]  key;
  logic        key_illegal;
  logic [4:0]  key_new;
  logic        illegal_wr;
  logic        pin_rst;
  logic        fault_done;
  logic        ovf_full;
  logic        full_rst;
  logic [31:0] rdata;

  // ----------------------------------------
  // decode
  // ----------------------------------------
  assign wr          = psel && penable && pwrite;
  assign rd          = psel && penable && !pwrite;
  assign key         = st.ctrl[`WDT_KEY_HI:`WDT_KEY_LO];
  assign key_illegal = (key != `WDT_KEY_ON) && (key != `WDT_KEY_OFF);
  assign key_new     = pwdata[`WDT_KEY_HI:`WDT_KEY_LO];
  assign illegal_wr  = wr && (paddr == `WDT_OFS_CTRL) && (key_new != `WDT_KEY_ON) && (key_new != `WDT_KEY_OFF);
  assign pin_rst     = (st.pinkey == `WDT_PINKEY_RES) && !pin_lvl;
  assign fault_done  = (st.fault == wdt_pkg::WDT_F_WAIT) && (st.fcnt == '0);
  assign ovf_full    = ci.ovf && !cpu_low_power;
  assign full_rst    = fault_done || ovf_full || pin_rst;

  always_comb begin
    addr_ok = 1'b1;
    unique case (paddr)
      `WDT_OFS_CTRL:   rdata = {24'h000000, st.ctrl};
      `WDT_OFS_CAUSE:  rdata = {31'h00000000, st.key_fault};
      `WDT_OFS_PINKEY: rdata = {24'h000000, st.pinkey};
      `WDT_OFS_STAT:   rdata = {30'h00000000, st.pdown, st.timeout};
      `WDT_OFS_IRQ:    rdata = {30'h00000000, st.irq_stat};
      `WDT_OFS_MASK:   rdata = {30'h00000000, st.irq_mask};
      default: begin
        rdata   = 32'h00000000;
        addr_ok = 1'b0;
      end
    endcase
  end

  // ----------------------------------------
  // counter control
  // ----------------------------------------
  assign ci.tick  = rc_rise;
  // software keeps the counter from overflowing with the clear input
  assign ci.clear = illegal_wr || watchdog_clear_instruction || sleep_instruction
                    || pin_rst || full_rst;
  assign ci.run   = (key == `WDT_KEY_ON) && (st.fault == wdt_pkg::WDT_F_IDLE);
  assign ci.sel   = st.ctrl[`WDT_SEL_HI:0];

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    next_st            = st;
    next_st.pcsp_reset = 1'b0;
    next_st.cpu_reset  = full_rst;
    if (psel && !penable) begin
      next_st.prdata = rdata;
    end
    if (wr) begin
      unique case (paddr)
        `WDT_OFS_CTRL:   next_st.ctrl = pwdata[7:0];
        `WDT_OFS_CAUSE: begin
          // writing one leaves the flag alone
          if (!pwdata[0]) begin
            next_st.key_fault = 1'b0;
          end
        end
        `WDT_OFS_PINKEY: next_st.pinkey = pwdata[7:0];
        `WDT_OFS_MASK:   next_st.irq_mask = pwdata[1:0];
        default: begin
        end
      endcase
    end
    if (rd && paddr == `WDT_OFS_IRQ) begin
      next_st.irq_stat = 2'h0;
    end
    // a corrupted key is caught from the stored value, not only from writes
    unique case (st.fault)
      wdt_pkg::WDT_F_IDLE: begin
        if (key_illegal) begin
          next_st.fault = wdt_pkg::WDT_F_WAIT;
          next_st.fcnt  = FCNT_LOAD;
        end
      end
      wdt_pkg::WDT_F_WAIT: begin
        if (fault_done) begin
          next_st.fault = wdt_pkg::WDT_F_IDLE;
        end else begin
          next_st.fcnt = st.fcnt - `WDT_FCNT_W'(1);
        end
      end
    endcase
    if (watchdog_clear_instruction) begin
      next_st.pdown = 1'b0;
    end
    if (sleep_instruction) begin
      next_st.pdown   = 1'b1;
      next_st.timeout = 1'b0;
    end
    // hardware sets after the software clears so a same-cycle event survives
    if (fault_done) begin
      next_st.key_fault = 1'b1;
      next_st.irq_stat[`WDT_IRQ_KEY] = 1'b1;
    end
    if (ci.ovf) begin
      next_st.timeout = 1'b1;
      next_st.irq_stat[`WDT_IRQ_OVF] = 1'b1;
      if (cpu_low_power) begin
        next_st.pcsp_reset = 1'b1;
      end
    end
    // device reset restores the control key; pin reset keeps the pin key so the pin stays a reset
    if (full_rst) begin
      next_st.ctrl = `WDT_CTRL_POR;
    end
    if (fault_done || ovf_full) begin
      next_st.pinkey = `WDT_PINKEY_POR;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_sys_n) begin
    if (!rst_sys_n) begin
      st <= ST_RST;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign prdata      = st.prdata;
  assign pready      = 1'b1;
  assign pslverr     = psel && penable && !addr_ok;
  assign cpu_reset   = st.cpu_reset;
  assign pc_sp_reset = st.pcsp_reset;
  assign irq         = |(st.irq_stat & st.irq_mask);

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_sys_n);

  a_fault_start: assert property ((st.fault == wdt_pkg::WDT_F_IDLE && key_illegal)
                                  |=> st.fault == wdt_pkg::WDT_F_WAIT && st.fcnt == FCNT_LOAD)
    else $error("illegal key did not start the fault delay");
  a_fault_reset: assert property (fault_done |=> st.cpu_reset && st.key_fault && st.ctrl == `WDT_CTRL_POR)
    else $error("fault delay end without reset and flag");
  a_flag_sticky: assert property (st.key_fault && !(wr && paddr == `WDT_OFS_CAUSE && !pwdata[0])
                                  |=> st.key_fault)
    else $error("fault flag lost without a zero write");
  a_flag_no_set: assert property ((!st.key_fault && !fault_done) |=> !st.key_fault)
    else $error("fault flag set without a key fault");
  a_ovf_full: assert property ((ci.ovf && !cpu_low_power) |=> st.cpu_reset && st.timeout && !st.pcsp_reset)
    else $error("normal overflow did not reset the device");
  a_ovf_warm: assert property ((ci.ovf && cpu_low_power && !fault_done && !pin_rst)
                               |=> st.pcsp_reset && !st.cpu_reset && st.timeout)
    else $error("low power overflow reset the wrong state");
  a_sleep_flags: assert property ((sleep_instruction && !ci.ovf) |=> st.pdown && !st.timeout)
    else $error("sleep did not update power-down and timeout flags");
  a_clear_pdf: assert property ((watchdog_clear_instruction && !sleep_instruction) |=> !st.pdown)
    else $error("clear instruction kept power-down flag");
  a_pin_reset: assert property ((!pin_lvl && st.pinkey == `WDT_PINKEY_RES) |=> st.cpu_reset ##0 ci.count == '0)
    else $error("selected reset pin had no effect");
  a_pin_ignored: assert property ((st.pinkey != `WDT_PINKEY_RES && !fault_done && !ci.ovf) |=> !st.cpu_reset)
    else $error("unselected pin caused a reset");
  a_cause_zero: assert property (rd && paddr == `WDT_OFS_CAUSE |-> prdata[7:1] == 7'h00)
    else $error("reserved reset-cause bits not zero");

  c_ovf_normal: cover property (ci.ovf && !cpu_low_power);
  c_ovf_sleep:  cover property (ci.ovf && cpu_low_power);
  c_key_fault:  cover property (fault_done);
  c_pin_reset:  cover property (pin_rst);

endmodule

//--- logic/wdt_consts.svh
// register offsets, field positions, reset values and timing counts of the watchdog
`ifndef WDT_CONSTS_SVH
`define WDT_CONSTS_SVH

// ----------------------------------------
// register byte offsets on the bus
// ----------------------------------------
`define WDT_OFS_CTRL      8'h00
`define WDT_OFS_CAUSE     8'h04
`define WDT_OFS_PINKEY    8'h08
`define WDT_OFS_STAT      8'h0C
`define WDT_OFS_IRQ       8'h10
`define WDT_OFS_MASK      8'h14

// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define WDT_CTRL_POR      8'h53
`define WDT_PINKEY_POR    8'h55
`define WDT_PINKEY_RES    8'hAA
`define WDT_KEY_HI        7
`define WDT_KEY_LO        3
`define WDT_SEL_HI        2
`define WDT_KEY_OFF       5'h15
`define WDT_KEY_ON        5'h0A
`define WDT_STAT_TO       0
`define WDT_STAT_PDF      1
`define WDT_IRQ_OVF       0
`define WDT_IRQ_KEY       1

// ----------------------------------------
// widths and timing
// ----------------------------------------
`define WDT_CNT_W         18
`define WDT_FCNT_W        16
`define WDT_RC_KHZ        32
`define WDT_KEY_FAULT_CYC 100

`endif

//--- logic/wdt_pkg.sv
// types shared by the watchdog modules
`include "wdt_consts.svh"

package wdt_pkg;

  typedef enum logic [0:0] {
    WDT_F_IDLE = 1'b0,
    WDT_F_WAIT = 1'b1
  } wdt_fault_e;

  typedef struct packed {
    logic [`WDT_CNT_W-1:0] cnt;
    logic                  ovf;
  } wdt_cnt_s;

  typedef struct packed {
    logic [7:0]             ctrl;
    logic [7:0]             pinkey;
    logic                   key_fault;
    logic                   timeout;
    logic                   pdown;
    logic [1:0]             irq_stat;
    logic [1:0]             irq_mask;
    wdt_fault_e             fault;
    logic [`WDT_FCNT_W-1:0] fcnt;
    logic [31:0]            prdata;
    logic                   cpu_reset;
    logic                   pcsp_reset;
  } wdt_top_s;

endpackage

//--- logic/wdt_cnt_if.sv
// link between the watchdog control logic and its counter
`timescale 1ns/1ps
`include "wdt_consts.svh"

interface wdt_cnt_if;
  logic                  tick;
  logic                  clear;
  logic                  run;
  logic [2:0]            sel;
  logic [`WDT_CNT_W-1:0] count;
  logic                  ovf;

  modport ctl (output tick, output clear, output run, output sel, input count, input ovf);
  modport cnt (input tick, input clear, input run, input sel, output count, output ovf);
endinterface

//--- logic/wdt_sync3.sv
// three-stage pin synchroniser with agreement filter and edge pulses
`timescale 1ns/1ps

module wdt_sync3 #(
  parameter logic INIT = 1'b0
) (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic rst_sys_n,
  // pin and filtered result
  input  wire logic d,
  output logic      lvl,
  output logic      rise,
  output logic      fall
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
    logic rise;
    logic fall;
  } wdt_sync_s;

  wdt_sync_s st;
  wdt_sync_s next_st;

  always_comb begin
    next_st      = st;
    next_st.s1   = d;
    next_st.s2   = st.s1;
    next_st.s3   = st.s2;
    next_st.rise = 1'b0;
    next_st.fall = 1'b0;
    // only stages two and three are compared; stage one may be metastable
    if (st.s2 == st.s3 && st.s3 != st.lvl) begin
      next_st.lvl  = st.s3;
      next_st.rise = st.s3;
      next_st.fall = ~st.s3;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_sys_n) begin
    if (!rst_sys_n) begin
      st <= '{s1: INIT, s2: INIT, s3: INIT, lvl: INIT, rise: 1'b0, fall: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign lvl  = st.lvl;
  assign rise = st.rise;
  assign fall = st.fall;

endmodule

//--- logic/wdt_counter.sv
// eighteen-bit watchdog up-counter with selectable overflow tap
`timescale 1ns/1ps
`include "wdt_consts.svh"

module wdt_counter (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic rst_sys_n,
  // control side
  wdt_cnt_if.cnt    ci
);

  wdt_pkg::wdt_cnt_s     st;
  wdt_pkg::wdt_cnt_s     next_st;
  logic [`WDT_CNT_W-1:0] mask;

  always_comb begin
    unique case (ci.sel)
      3'h0: mask = 18'h000FF;
      3'h1: mask = 18'h003FF;
      3'h2: mask = 18'h00FFF;
      3'h3: mask = 18'h03FFF;
      3'h4: mask = 18'h07FFF;
      3'h5: mask = 18'h0FFFF;
      3'h6: mask = 18'h1FFFF;
      3'h7: mask = 18'h3FFFF;
    endcase
  end

  always_comb begin
    next_st     = st;
    next_st.ovf = 1'b0;
    if (ci.clear) begin
      next_st.cnt = '0;
    end else if (ci.run && ci.tick) begin
      if ((st.cnt & mask) == mask) begin
        next_st.cnt = '0;
        next_st.ovf = 1'b1;
      end else begin
        next_st.cnt = st.cnt + 18'h00001;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_sys_n) begin
    if (!rst_sys_n) begin
      st <= '{cnt: '0, ovf: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign ci.count = st.cnt;
  assign ci.ovf   = st.ovf;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_sys_n);

  a_count_clear: assert property (ci.clear |=> st.cnt == '0)
    else $error("counter not cleared");
  a_ovf_tap: assert property (st.ovf |-> ($past(st.cnt & mask) == $past(mask)) && $past(ci.tick))
    else $error("overflow without full selected span");

endmodule

//--- tb/tb_top.sv
// self-checking bench for the watchdog block
`timescale 1ns/1ps

module tb_top;
  logic        clk_sys;
  logic        rst_n;
  logic [7:0]  paddr;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        wclr;
  logic        sleep_i;
  logic        low_pwr;
  logic        cpu_reset;
  logic        pc_sp_reset;
  logic        irq;
  logic        slow_rc;
  logic        ext_pin_n;
  int          mismatches;
  int          n_tests;
  int          n_rst;
  int          n_pcsp;
  int          base;
  int          base2;
  logic [31:0] rd;
  logic        err;
  logic [4:0]  key;
  int unsigned r;

  // short fault delay keeps the run brief
  wdt_top #(.KEY_FAULT_CYCLES(4)) u_dut (
    .clk_sys                   (clk_sys),
    .rst_n                     (rst_n),
    .paddr                     (paddr),
    .psel                      (psel),
    .penable                   (penable),
    .pwrite                    (pwrite),
    .pwdata                    (pwdata),
    .prdata                    (prdata),
    .pready                    (pready),
    .pslverr                   (pslverr),
    .watchdog_clear_instruction(wclr),
    .sleep_instruction         (sleep_i),
    .cpu_low_power             (low_pwr),
    .cpu_reset                 (cpu_reset),
    .pc_sp_reset               (pc_sp_reset),
    .irq                       (irq),
    .slow_rc_clock             (slow_rc),
    .ext_nrst_pin              (ext_pin_n)
  );

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // count reset events seen at the core side
  always @(posedge clk_sys) begin
    if (cpu_reset === 1'b1) n_rst++;
    if (pc_sp_reset === 1'b1) n_pcsp++;
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] ctrl_val(input logic [4:0] k, input logic [2:0] s);
    return {24'h0, k, s};
  endfunction

  function automatic int unsigned ovf_ticks(input logic [2:0] s);
    int unsigned e[8] = '{8, 10, 12, 14, 15, 16, 17, 18};
    return 1 << e[s];
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // one apb transfer; the master waits for pready, never a fixed count
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    // only the watchdog process ends a wait that never completes
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic ticks(input int unsigned n);
    repeat (n) begin
      slow_rc <= 1'b1;
      repeat (3) @(posedge clk_sys);
      slow_rc <= 1'b0;
      repeat (3) @(posedge clk_sys);
    end
  endtask

  task automatic strobe(input bit slp);
    @(posedge clk_sys);
    if (slp) begin
      sleep_i <= 1'b1;
    end else begin
      wclr <= 1'b1;
    end
    @(posedge clk_sys);
    sleep_i <= 1'b0;
    wclr    <= 1'b0;
    repeat (2) @(posedge clk_sys);
  endtask

  // overflow at exactly 2^N ticks, normal or low-power response
  task automatic ovf_run(input logic [2:0] s, input logic lp);
    apb(1'b1, 8'h00, ctrl_val(5'h0A, s));
    low_pwr <= lp;
    strobe(1'b1);
    apb(1'b0, 8'h0C, 32'h0);
    chk(rd, 32'h2);
    strobe(1'b0);
    apb(1'b0, 8'h0C, 32'h0);
    chk(rd, 32'h0);
    base = n_rst;
    base2 = n_pcsp;
    ticks(ovf_ticks(s) - 1);
    repeat (10) @(posedge clk_sys);
    chk(n_rst + n_pcsp - base - base2, 0);
    ticks(1);
    repeat (10) @(posedge clk_sys);
    chk(n_rst - base, lp ? 0 : 1);
    chk(n_pcsp - base2, lp ? 1 : 0);
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, lp ? ctrl_val(5'h0A, s) : 32'h53);
    apb(1'b0, 8'h0C, 32'h0);
    chk(rd[0], 1'b1);
    @(negedge clk_sys);
    chk(irq, 1'b1);
    apb(1'b0, 8'h10, 32'h0);
    chk(rd, 32'h1);
    @(negedge clk_sys);
    chk(irq, 1'b0);
    // inputs only move on a rising edge
    @(posedge clk_sys);
    low_pwr <= 1'b0;
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    rst_n = 1'b0;
    paddr = 8'h00;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    pwdata = 32'h0;
    wclr = 1'b0;
    sleep_i = 1'b0;
    low_pwr = 1'b0;
    slow_rc = 1'b0;
    ext_pin_n = 1'b1;
    mismatches = 0;
    n_tests = 0;
    n_rst = 0;
    n_pcsp = 0;
    r = $urandom(82716);
    repeat (3) @(posedge clk_sys);
    chk({pready, cpu_reset, pc_sp_reset}, 3'b110);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h53);
    apb(1'b0, 8'h04, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 8'h08, 32'h0);
    chk(rd, 32'h55);
    apb(1'b1, 8'h18, 32'hFF);
    apb(1'b0, 8'h18, 32'h0);
    chk(rd, 32'h0);
    chk(err, 1'b1);
    apb(1'b1, 8'h14, 32'h1);
    // system clock alone must never advance the count
    apb(1'b1, 8'h00, ctrl_val(5'h0A, 3'd0));
    strobe(1'b0);
    base = n_rst;
    repeat (2000) @(posedge clk_sys);
    chk(n_rst - base, 0);
    for (int s = 0; s < 3; s++) begin
      ovf_run(s[2:0], 1'b0);
    end
    ovf_run(3'd0, 1'b1);
    apb(1'b1, 8'h00, ctrl_val(5'h15, 3'd0));
    strobe(1'b0);
    base = n_rst;
    ticks(300);
    chk(n_rst - base, 0);
    // clears restart the count at random points, sleep at a count of 255
    apb(1'b1, 8'h00, ctrl_val(5'h0A, 3'd0));
    strobe(1'b0);
    base = n_rst;
    // the two clears at random points are each followed by 255 ticks, so a missed clear or sleep overflows
    r = $urandom_range(255, 1);
    ticks(r);
    strobe(1'b0);
    ticks(255);
    strobe(1'b1);
    r = $urandom_range(255, 1);
    ticks(r);
    strobe(1'b0);
    ticks(255);
    chk(n_rst - base, 0);
    key = 5'($urandom_range(31, 0));
    if (key == 5'h0A || key == 5'h15) begin
      key = 5'h1F;
    end
    base = n_rst;
    apb(1'b1, 8'h00, ctrl_val(key, 3'($urandom_range(7, 0))));
    repeat (20) @(posedge clk_sys);
    chk(n_rst - base, 1);
    apb(1'b0, 8'h04, 32'h0);
    chk(rd, 32'h1);
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h53);
    @(negedge clk_sys);
    chk(irq, 1'b0);
    apb(1'b0, 8'h10, 32'h0);
    chk(rd, 32'h2);
    apb(1'b1, 8'h04, 32'h1);
    apb(1'b0, 8'h04, 32'h0);
    chk(rd, 32'h1);
    apb(1'b1, 8'h04, 32'h0);
    apb(1'b0, 8'h04, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, 8'h04, 32'h1);
    apb(1'b0, 8'h04, 32'h0);
    chk(rd, 32'h0);
    // pin acts as reset only under its key
    apb(1'b1, 8'h08, 32'hAA);
    ext_pin_n <= 1'b0;
    repeat (10) @(posedge clk_sys);
    chk(cpu_reset, 1'b1);
    ext_pin_n <= 1'b1;
    repeat (10) @(posedge clk_sys);
    apb(1'b0, 8'h08, 32'h0);
    chk(rd, 32'hAA);
    apb(1'b1, 8'h08, 32'h55);
    ext_pin_n <= 1'b0;
    repeat (10) @(posedge clk_sys);
    chk(cpu_reset, 1'b0);
    ext_pin_n <= 1'b1;
    conclude();
  end

  initial begin
    repeat (80000) @(posedge clk_sys);
    mismatches++;
    conclude();
  end
endmodule
